// File: fispc_pkg.sv
// Shared constants and types for the bus init, stall and priority control
package fispc_pkg;

  // ************************************************************
  // Timing counts (cycles of ref_clk)
  // ************************************************************
  localparam logic [1:0] CFG_SETTLE_CNT  = 2'h2; // Strap capture delay
  localparam logic [1:0] REINIT_HOLD_CNT = 2'h3; // Reinit drive length
  localparam logic       STALL_DRV_PHASE = 1'h0; // Phase on which stall moves
  localparam logic       STALL_SMP_PHASE = 1'h1; // Phase on which stall read

  // ************************************************************
  // Queue sizing and reset values
  // ************************************************************
  localparam logic [2:0] IOQ_MAX         = 3'h4; // In-order queue entries
  localparam logic [2:0] IOQ_EMPTY       = 3'h0;
  localparam logic [5:0] BPM_OE_RST      = 6'h00;

  // ************************************************************
  // Bit positions of the breakpoint/monitor lines
  // ************************************************************
  localparam int unsigned BPM_READY_BIT  = 4;    // Probe ready out
  localparam int unsigned BPM_REQ_BIT    = 5;    // Probe request in

  // ************************************************************
  // Request arbitration states
  // ************************************************************
  typedef enum logic [1:0] {
    ARB_IDLE  = 2'b00,
    ARB_ISSUE = 2'b01,
    ARB_HOLD  = 2'b10
  } fispc_arb_t;

  // Levels seen on the shared lines (active low)
  typedef struct packed {
    logic       reinit_n;
    logic       stall_n;
    logic       prio_n;
    logic       probe_req_n;
  } fispc_pin_in_t;

  // Open-drain drive of the shared lines
  typedef struct packed {
    logic       reinit_oe;
    logic       stall_oe;
    logic       ads_oe;
    logic [5:0] bpm_oe;
  } fispc_pin_oe_t;

endpackage

// File: fispc_ctrl.sv
// Front side bus reinit, stall, priority and probe control logic
`timescale 1ns/1ps
// Function
// - Drive reinit on fatal bus condition if enabled
// - Observed reinit resets lock hold and arbitration
// - Reinit leaves in-order queue and tracking intact
// - After reinit, rearbitrate and reissue pending work
// - Agent unable to accept transactions asserts stall
// - Owner starts no transaction during stall
// - Stall driven and sampled on designated edges
// - Drive four breakpoint/monitor status outputs
// - Monitor line four is probe ready output
// - Probe ready and request lines are shared
// - Priority request stops new non-locked requests
// - Address strobe marks start of transaction
// - Drive and latch on the bus clock edge
module fispc_ctrl
  import fispc_pkg::*;
(
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rstn,
  // Power-on straps
  input  wire logic                     cfg_reinit_drive_en,
  input  wire logic                     cfg_reinit_observe_en,
  // Shared bus lines, input side
  input  wire fispc_pkg::fispc_pin_in_t pins_in,
  // Shared bus lines, open-drain output side
  output logic                          bus_reinit_n_out,
  output logic                          block_next_req_n_out,
  output logic                          addr_strobe_n_out,
  output logic [5:0]                    breakpoint_monitor_n_out,
  output fispc_pkg::fispc_pin_oe_t      pins_oe,
  // Core request side
  input  wire logic                     req_valid,
  input  wire logic                     req_locked,
  input  wire logic                     lock_active,
  input  wire logic                     txn_done,
  input  wire logic                     core_busy,
  input  wire logic                     fatal_err,
  output logic                          req_ready,
  output logic                          req_issued,
  // Debug and status side
  input  wire logic [3:0]               bp_status,
  input  wire logic                     probe_ready,
  output logic                          probe_request,
  output logic                          reinit_seen,
  output logic [2:0]                    ioq_level
);
  import fispc_pkg::*;

  fispc_pin_in_t sync1_reg;
  fispc_pin_in_t sync2_reg;
  logic          reinit_prev_reg;
  logic [1:0]    cfg_cnt_reg;
  logic          cfg_done_reg;
  logic          drive_en_reg;
  logic          observe_en_reg;
  logic [1:0]    reinit_cnt_reg;
  logic          phase_reg;
  logic          stall_seen_reg;
  logic          pend_reg;
  logic          pend_locked_reg;
  logic          lock_hold_reg;
  logic [2:0]    ioq_reg;
  fispc_arb_t    arb_reg;
  fispc_arb_t    arb_next;
  logic          reinit_evt;
  logic          can_issue;
  logic          ioq_full;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // Two stages; only the second is read
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
    end else begin
      sync1_reg <= pins_in;
      sync2_reg <= sync1_reg;
    end
  end

  // ************************************************************
  // Strap capture
  // ************************************************************
  // Enables frozen a few cycles after reset release
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_cnt_reg    <= 2'h0;
      cfg_done_reg   <= 1'b0;
      drive_en_reg   <= 1'b0;
      observe_en_reg <= 1'b0;
    end else if (!cfg_done_reg) begin
      if (cfg_cnt_reg == CFG_SETTLE_CNT) begin
        cfg_done_reg   <= 1'b1;
        drive_en_reg   <= cfg_reinit_drive_en;
        observe_en_reg <= cfg_reinit_observe_en;
      end else begin
        cfg_cnt_reg <= cfg_cnt_reg + 2'h1;
      end
    end
  end

  // ************************************************************
  // Bus reinit drive and observe
  // ************************************************************
  // Falling edge of the low-active line while observing
  assign reinit_evt = observe_en_reg && reinit_prev_reg
                      && !sync2_reg.reinit_n;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reinit_prev_reg <= 1'b1;
      reinit_seen     <= 1'b0;
    end else begin
      reinit_prev_reg <= sync2_reg.reinit_n;
      reinit_seen     <= reinit_evt;
    end
  end

  // Hold the line low for a fixed time on a fatal condition
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reinit_cnt_reg <= 2'h0;
    end else if (drive_en_reg && fatal_err) begin
      reinit_cnt_reg <= REINIT_HOLD_CNT;
    end else if (reinit_cnt_reg != 2'h0) begin
      reinit_cnt_reg <= reinit_cnt_reg - 2'h1;
    end
  end

  // ************************************************************
  // Stall request on designated edges
  // ************************************************************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phase_reg <= STALL_DRV_PHASE;
    end else begin
      phase_reg <= ~phase_reg;
    end
  end

  assign ioq_full = (ioq_reg == IOQ_MAX);

  // Sample the shared stall only on the sample phase
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stall_seen_reg <= 1'b0;
    end else if (phase_reg == STALL_SMP_PHASE) begin
      stall_seen_reg <= !sync2_reg.stall_n;
    end
  end

  // ************************************************************
  // Pending request and lock hold
  // ************************************************************
  // Pending work survives reinit so it is issued again
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pend_reg        <= 1'b0;
      pend_locked_reg <= 1'b0;
    end else if (req_valid && req_ready) begin
      pend_reg        <= 1'b1;
      pend_locked_reg <= req_locked;
    end else if (arb_reg == ARB_ISSUE) begin
      pend_reg        <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= cfg_done_reg && !pend_reg && !(req_valid && req_ready);
    end
  end

  // Locked sequence hold, dropped by reinit
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lock_hold_reg <= 1'b0;
    end else if (reinit_evt || !lock_active) begin
      lock_hold_reg <= 1'b0;
    end else if (arb_reg == ARB_ISSUE && pend_locked_reg) begin
      lock_hold_reg <= 1'b1;
    end
  end

  // ************************************************************
  // In-order queue tracking
  // ************************************************************
  // Not touched by reinit
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ioq_reg <= IOQ_EMPTY;
    end else begin
      case ({arb_reg == ARB_ISSUE, txn_done && ioq_reg != IOQ_EMPTY})
        2'b10:   ioq_reg <= ioq_reg + 3'h1;
        2'b01:   ioq_reg <= ioq_reg - 3'h1;
        default: ioq_reg <= ioq_reg;
      endcase
    end
  end

  // ************************************************************
  // Request arbitration
  // ************************************************************
  // Priority agent blocks all but locked follow-ons
  assign can_issue = pend_reg && !stall_seen_reg && !ioq_full
                     && (sync2_reg.prio_n
                         || (lock_hold_reg && pend_locked_reg));

  // One issue cycle, one hold cycle, then back to idle
  always_comb begin
    arb_next = arb_reg;
    case (arb_reg)
      ARB_IDLE:  arb_next = can_issue ? ARB_ISSUE : ARB_IDLE;
      ARB_ISSUE: arb_next = ARB_HOLD;
      ARB_HOLD:  arb_next = ARB_IDLE;
      default:   arb_next = ARB_IDLE;
    endcase
  end

  // Reinit returns arbitration to idle to rearbitrate
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      arb_reg <= ARB_IDLE;
    end else if (reinit_evt) begin
      arb_reg <= ARB_IDLE;
    end else begin
      arb_reg <= arb_next;
    end
  end

  // ************************************************************
  // Output registers
  // ************************************************************
  // Open-drain: level is low, enable asserts the line
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pins_oe                  <= '0;
      bus_reinit_n_out         <= 1'b0;
      block_next_req_n_out     <= 1'b0;
      addr_strobe_n_out        <= 1'b0;
      breakpoint_monitor_n_out <= 6'h00;
      req_issued               <= 1'b0;
      probe_request            <= 1'b0;
      ioq_level                <= IOQ_EMPTY;
    end else begin
      pins_oe.reinit_oe <= drive_en_reg && (fatal_err
                           || reinit_cnt_reg != 2'h0);
      if (phase_reg == STALL_DRV_PHASE) begin
        pins_oe.stall_oe <= core_busy || ioq_full;
      end
      pins_oe.ads_oe <= (arb_next == ARB_ISSUE) && !reinit_evt;
      pins_oe.bpm_oe[3:0] <= bp_status;
      pins_oe.bpm_oe[BPM_READY_BIT] <= probe_ready;
      pins_oe.bpm_oe[BPM_REQ_BIT] <= 1'b0;
      req_issued    <= (arb_next == ARB_ISSUE) && !reinit_evt;
      probe_request <= !sync2_reg.probe_req_n;
      ioq_level     <= ioq_reg;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence issue_s;
    arb_reg == ARB_IDLE && can_issue && !reinit_evt;
  endsequence
  sequence strobe_s;
    pins_oe.ads_oe ##1 !pins_oe.ads_oe;
  endsequence
  strobe_on_issue_a: assert property (
    @(posedge ref_clk) disable iff (!rstn) issue_s |=> strobe_s)
    else $error("address strobe missing after issue");
  no_issue_stall_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $rose(pins_oe.ads_oe) |-> !$past(stall_seen_reg))
    else $error("transaction started during stall");
  // Only a locked follow-on may pass the priority agent
  prio_blocks_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $rose(pins_oe.ads_oe) |-> $past(sync2_reg.prio_n)
      || ($past(lock_hold_reg) && $past(pend_locked_reg)))
    else $error("request issued under priority agent");
  stall_edge_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $changed(pins_oe.stall_oe) |-> $past(phase_reg) == STALL_DRV_PHASE)
    else $error("stall moved on wrong edge");
  reinit_arb_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    reinit_evt |=> arb_reg == ARB_IDLE && !lock_hold_reg && reinit_seen)
    else $error("reinit did not reset arbitration");
  ioq_kept_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    reinit_evt && !txn_done && arb_reg != ARB_ISSUE |=> $stable(ioq_reg))
    else $error("in-order queue changed on reinit");
  reinit_drive_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    drive_en_reg && fatal_err |=> pins_oe.reinit_oe [*3])
    else $error("reinit not driven on fatal error");
  straps_fixed_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    cfg_done_reg |=> $stable(drive_en_reg) && $stable(observe_en_reg))
    else $error("reinit enables changed after capture");
  // First edge after reset still shows the cleared flop
  probe_ready_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $past(rstn) |-> pins_oe.bpm_oe[BPM_READY_BIT] == $past(probe_ready)
    && !pins_oe.bpm_oe[BPM_REQ_BIT])
    else $error("probe ready line wrong");
  // A request already in its issue cycle has left the pending slot
  reissue_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    reinit_evt && pend_reg && arb_reg != ARB_ISSUE |=> pend_reg)
    else $error("pending request lost on reinit");
endmodule

// File: fispc_far_agents.sv
// Far side model: other bus agents, priority agent and debug probe
`timescale 1ns/1ps
module fispc_far_agents
  import fispc_pkg::*;
#(
  parameter logic [5:0] PRIO_HOLD = 6'h18
)
(
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rstn,
  // Commands from the bench
  input  wire logic                     reinit_cmd,
  input  wire logic                     stall_cmd,
  input  wire logic                     prio_go,
  input  wire logic                     probe_cmd,
  // Shared lines
  input  wire fispc_pkg::fispc_pin_oe_t pins_oe,
  output fispc_pkg::fispc_pin_in_t      pins_in
);
  import fispc_pkg::*;

  logic       phase_reg;
  logic       stall_drv_reg;
  logic [5:0] prio_cnt_reg;

  // Other agent moves its stall drive only on even phase
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phase_reg     <= 1'h0;
      stall_drv_reg <= 1'h0;
    end else begin
      phase_reg <= ~phase_reg;
      if (!phase_reg) begin
        stall_drv_reg <= stall_cmd;
      end
    end
  end

  // Priority agent holds its request for PRIO_HOLD cycles after prio_go, then releases it
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prio_cnt_reg <= 6'h00;
    end else if (prio_go) begin
      prio_cnt_reg <= PRIO_HOLD;
    end else if (prio_cnt_reg != 6'h00) begin
      prio_cnt_reg <= prio_cnt_reg - 6'h01;
    end
  end

  // Wire-OR with pull-up: a line is low while any party drives it
  assign pins_in.reinit_n    = ~(reinit_cmd | pins_oe.reinit_oe);
  assign pins_in.stall_n     = ~(stall_drv_reg | pins_oe.stall_oe);
  assign pins_in.prio_n      = ~(prio_cnt_reg != 6'h00);
  assign pins_in.probe_req_n = ~(probe_cmd | pins_oe.bpm_oe[BPM_REQ_BIT]);
endmodule

// File: fsb_init_stall_priority_ctrl_tb.sv
// Self-checking bench for the bus reinit, stall and priority control
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
  bad_count++; $display("Error %s exp %0h got %0h", nm, e, g); end end
module fsb_init_stall_priority_ctrl_tb;
  import fispc_pkg::*;

  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic drv_en = 1'b1;
  logic obs_en = 1'b1;
  logic req_valid = 1'b0;
  logic txn_done = 1'b0;
  logic core_busy = 1'b0;
  logic fatal_err = 1'b0;
  logic [3:0] bp_status = 4'h0;
  logic probe_ready = 1'b0;
  logic reinit_cmd = 1'b0;
  logic stall_cmd = 1'b0;
  logic prio_go = 1'b0;
  logic probe_cmd = 1'b0;
  logic req_locked = 1'b0;
  logic lock_active = 1'b0;
  logic bus_reinit_n_out, block_next_req_n_out, addr_strobe_n_out;
  logic [5:0] breakpoint_monitor_n_out;
  logic [8:0] od_levels;
  logic req_ready, req_issued, probe_request, reinit_seen, seen;
  logic [2:0] ioq_level, lvl;
  fispc_pin_in_t pins_in;
  fispc_pin_oe_t pins_oe;
  int bad_count = 0;
  int checked = 0;

  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;

  // Open-drain output levels gathered for one compare
  assign od_levels = {bus_reinit_n_out, block_next_req_n_out,
                      addr_strobe_n_out, breakpoint_monitor_n_out};

  // Design and far side
  fispc_ctrl u_fispc_ctrl (.ref_clk(ref_clk), .rstn(rstn),
    .cfg_reinit_drive_en(drv_en), .cfg_reinit_observe_en(obs_en),
    .pins_in(pins_in), .bus_reinit_n_out(bus_reinit_n_out),
    .block_next_req_n_out(block_next_req_n_out),
    .addr_strobe_n_out(addr_strobe_n_out),
    .breakpoint_monitor_n_out(breakpoint_monitor_n_out),
    .pins_oe(pins_oe), .req_valid(req_valid), .req_locked(req_locked),
    .lock_active(lock_active), .txn_done(txn_done), .core_busy(core_busy),
    .fatal_err(fatal_err), .req_ready(req_ready),
    .req_issued(req_issued), .bp_status(bp_status),
    .probe_ready(probe_ready), .probe_request(probe_request),
    .reinit_seen(reinit_seen), .ioq_level(ioq_level));
  fispc_far_agents u_fispc_far_agents (.ref_clk(ref_clk), .rstn(rstn),
    .reinit_cmd(reinit_cmd), .stall_cmd(stall_cmd), .prio_go(prio_go),
    .probe_cmd(probe_cmd), .pins_oe(pins_oe), .pins_in(pins_in));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wait_neg(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Hand one request over once ready is seen
  task automatic do_req;
    int i;
    i = 0;
    while (req_ready !== 1'b1 && i < 60) begin
      @(negedge ref_clk);
      i++;
    end
    @(posedge ref_clk) req_valid <= 1'b1;
    @(posedge ref_clk) req_valid <= 1'b0;
  endtask

  // Wait for the issue pulse, then check the strobe beside it
  task automatic issued_within(input int lim);
    int t;
    t = 0;
    do begin
      @(negedge ref_clk);
      t++;
    end while (req_issued !== 1'b1 && t < lim);
    `CHK("issued", 1'b1, req_issued)
    `CHK("ads_oe", 1'b1, pins_oe.ads_oe)
  endtask

  task automatic no_issue(input int n);
    seen = 1'b0;
    repeat (n) begin
      @(negedge ref_clk);
      if (req_issued === 1'b1) seen = 1'b1;
    end
  endtask

  task automatic retire;
    @(posedge ref_clk) txn_done <= 1'b1;
    @(posedge ref_clk) txn_done <= 1'b0;
    wait_neg(2);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_basic;
    lvl = ioq_level;
    do_req;
    issued_within(3);
    wait_neg(2);
    `CHK("ioq_up", lvl + 3'h1, ioq_level)
    retire;
    `CHK("ioq_down", lvl, ioq_level)
  endtask

  task automatic t_stall;
    @(posedge ref_clk) stall_cmd <= 1'b1;
    wait_neg(6);
    do_req;
    no_issue(20);
    `CHK("stalled", 1'b0, seen)
    @(posedge ref_clk) stall_cmd <= 1'b0;
    issued_within(12);
    retire;
  endtask

  task automatic t_busy;
    @(posedge ref_clk) core_busy <= 1'b1;
    wait_neg(3);
    `CHK("stall_on", 1'b1, pins_oe.stall_oe)
    @(posedge ref_clk) core_busy <= 1'b0;
    wait_neg(3);
    `CHK("stall_off", 1'b0, pins_oe.stall_oe)
  endtask

  task automatic t_prio;
    @(posedge ref_clk) prio_go <= 1'b1;
    @(posedge ref_clk) prio_go <= 1'b0;
    wait_neg(4);
    do_req;
    no_issue(12);
    `CHK("prio_block", 1'b0, seen)
    issued_within(20);
    retire;
  endtask

  // Fill the in-order queue: own stall goes up, next request waits
  task automatic t_fill;
    for (int i = 0; i < 4; i++) begin
      do_req;
      issued_within(6);
    end
    wait_neg(4);
    `CHK("ioq_full", IOQ_MAX, ioq_level)
    `CHK("full_stall", 1'b1, pins_oe.stall_oe)
    do_req;
    no_issue(10);
    `CHK("full_block", 1'b0, seen)
    retire;
    issued_within(12);
    repeat (4) retire;
    `CHK("ioq_drained", 3'h0, ioq_level)
  endtask

  // Locked follow-on passes the priority agent, unlocked one waits
  task automatic t_lock;
    @(posedge ref_clk) lock_active <= 1'b1;
    req_locked <= 1'b1;
    do_req;
    issued_within(6);
    retire;
    @(posedge ref_clk) prio_go <= 1'b1;
    @(posedge ref_clk) prio_go <= 1'b0;
    wait_neg(4);
    do_req;
    issued_within(6);
    `CHK("lock_pass", 1'b1, req_issued)
    retire;
    @(posedge ref_clk) lock_active <= 1'b0;
    req_locked <= 1'b0;
    do_req;
    no_issue(8);
    `CHK("unlock_block", 1'b0, seen)
    issued_within(30);
    retire;
  endtask

  // Reset again with both straps low: reinit neither driven nor obeyed
  task automatic t_straps_off;
    @(posedge ref_clk) rstn <= 1'b0;
    drv_en <= 1'b0;
    obs_en <= 1'b0;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    wait_neg(6);
    `CHK("ready_again", 1'b1, req_ready)
    @(posedge ref_clk) reinit_cmd <= 1'b1;
    fatal_err <= 1'b1;
    @(posedge ref_clk) reinit_cmd <= 1'b0;
    fatal_err <= 1'b0;
    wait_neg(1);
    `CHK("no_drive", 1'b0, pins_oe.reinit_oe)
    seen = 1'b0;
    repeat (6) begin
      @(negedge ref_clk);
      if (reinit_seen === 1'b1) seen = 1'b1;
    end
    `CHK("no_observe", 1'b0, seen)
  endtask

  task automatic t_bpm;
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk) bp_status <= 4'h1 << i;
      wait_neg(2);
      `CHK("bpm_stat", 4'h1 << i, pins_oe.bpm_oe[3:0])
    end
    @(posedge ref_clk) probe_ready <= 1'b1;
    wait_neg(2);
    `CHK("probe_rdy", 1'b1, pins_oe.bpm_oe[BPM_READY_BIT])
    @(posedge ref_clk) probe_cmd <= 1'b1;
    wait_neg(4);
    `CHK("probe_req", 1'b1, probe_request)
    `CHK("bpm5_free", 1'b0, pins_oe.bpm_oe[BPM_REQ_BIT])
    @(posedge ref_clk) probe_cmd <= 1'b0;
    wait_neg(4);
    `CHK("probe_idle", 1'b0, probe_request)
    `CHK("od_levels", 9'h000, od_levels)
  endtask

  // Straps dropped after capture must have no effect
  task automatic t_reinit;
    @(posedge ref_clk) obs_en <= 1'b0;
    drv_en <= 1'b0;
    stall_cmd <= 1'b1;
    wait_neg(6);
    do_req;
    wait_neg(4);
    lvl = ioq_level;
    @(posedge ref_clk) reinit_cmd <= 1'b1;
    @(posedge ref_clk) reinit_cmd <= 1'b0;
    seen = 1'b0;
    repeat (6) begin
      @(negedge ref_clk);
      if (reinit_seen === 1'b1) seen = 1'b1;
    end
    `CHK("reinit_seen", 1'b1, seen)
    `CHK("ioq_kept", lvl, ioq_level)
    @(posedge ref_clk) stall_cmd <= 1'b0;
    issued_within(14);
    retire;
  endtask

  task automatic t_fatal;
    @(posedge ref_clk) fatal_err <= 1'b1;
    @(posedge ref_clk) fatal_err <= 1'b0;
    wait_neg(1);
    `CHK("drive_on", 1'b1, pins_oe.reinit_oe)
    wait_neg(3);
    `CHK("drive_hold", 1'b1, pins_oe.reinit_oe)
    wait_neg(1);
    `CHK("drive_off", 1'b0, pins_oe.reinit_oe)
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK("rst_oe", 9'h000, pins_oe)
    `CHK("rst_ready", 1'b0, req_ready)
    @(posedge ref_clk) rstn <= 1'b1;
    t_basic;
    t_fill;
    t_stall;
    t_busy;
    t_prio;
    t_lock;
    t_bpm;
    t_reinit;
    t_fatal;
    t_straps_off;
    report_and_stop;
  end

  // Watchdog well beyond the expected run length
  initial begin
    #160000;
    bad_count++;
    report_and_stop;
  end
endmodule
